// ===== shared/octdac_consts.svh
// Constants for the octal converter serial front end.
`ifndef OCTDAC_CONSTS_SVH
`define OCTDAC_CONSTS_SVH
`define OCTDAC_WORD_BITS    16
`define OCTDAC_CODE_BITS    12
`define OCTDAC_ADDR_MSB     15
`define OCTDAC_ADDR_LSB     12
`define OCTDAC_CODE_RESET   12'h000
`define OCTDAC_MIDSCALE     12'h800
`define OCTDAC_CNT_LAST     5'h10
`define OCTDAC_ADDR_CTRL0   4'h8
`define OCTDAC_ADDR_CTRL1   4'h9
`define OCTDAC_ADDR_PRESET  4'hA
`define OCTDAC_ADDR_RSVD    4'hB
`define OCTDAC_PAIR_BIT     3
`define OCTDAC_CHAN_BIT     3
`endif

// ===== shared/octdac_pkg.sv
// Types for the octal converter serial front end.
package octdac_pkg;
   typedef enum logic [1:0] {
      OCTDAC_IDLE,
      OCTDAC_SHIFT,
      OCTDAC_HOLD
   } octdac_state_t;
   typedef logic [11:0] octdac_code_t;
endpackage

// ===== core/octdac_frontend.sv
// Serial input front end: shift register, mode handling, buffer and code registers.
`timescale 1ns/1ps
`include "octdac_consts.svh"

// Function
// RQ1 - Host holds frame sync low whole word
// RQ2 - Early frame sync rise cancels the word
// RQ3 - Word applied on next frame sync rise
// RQ4 - DSP mode accepts a short sync pulse
// RQ5 - Mode input high selects microcontroller mode
// RQ6 - Daisy output is input delayed sixteen clocks
// RQ7 - Power-up clears all converter codes
// RQ8 - Data sampled on serial clock falling edge
// RQ9 - Frame starts on frame sync falling
// RQ10 - Sixteen bits complete one word
// RQ11 - Codes are twelve-bit unsigned values
// RQ12 - Top four bits address, low twelve payload
// RQ13 - Address decodes sixteen destinations; the code writes nothing for reserved address 4'hB
// RQ14 - Codes pass on while load strobe low
// RQ15 - Words arrive most significant bit first
// RQ16 - DSP mode applies after sixteenth edge
module octdac_frontend (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  wire logic         i_sclk,
   input  wire logic         i_sdata,
   input  wire logic         i_frame_sync,
   input  wire logic         i_mode_mcu,
   input  wire logic         i_load_strobe_n,
   output logic              o_daisy_out,
   output logic [95:0]       o_dac_codes,
   output logic [11:0]       o_ctrl0,
   output logic [11:0]       o_ctrl1,
   output logic [11:0]       o_preset
);
   // Synchronisers for all pins.
   logic [4:0] s1_reg;
   logic [4:0] s2_reg;
   logic       sclk_d_reg;
   logic       fs_d_reg;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s1_reg     <= 5'h1F;
         s2_reg     <= 5'h1F;
         sclk_d_reg <= 1'b1;
         fs_d_reg   <= 1'b1;
      end else begin
         s1_reg     <= {i_sclk, i_sdata, i_frame_sync, i_mode_mcu, i_load_strobe_n};
         s2_reg     <= s1_reg;
         sclk_d_reg <= s2_reg[4];
         fs_d_reg   <= s2_reg[2];
      end
   end

   logic sclk_fall;
   logic fs_fall;
   logic fs_rise;
   logic sdata_s;
   logic mcu_mode;
   logic load_n_s;
   assign sclk_fall = sclk_d_reg & ~s2_reg[4]; // RQ8
   assign fs_fall   = fs_d_reg & ~s2_reg[2]; // RQ9
   assign fs_rise   = ~fs_d_reg & s2_reg[2];
   assign sdata_s   = s2_reg[3];
   assign mcu_mode  = s2_reg[1]; // RQ5
   assign load_n_s  = s2_reg[0];

   // Receiver state.
   octdac_pkg::octdac_state_t state_reg;
   octdac_pkg::octdac_state_t state_next;
   logic [15:0] shift_reg;
   logic [15:0] shift_next;
   logic [4:0]  cnt_reg;
   logic [4:0]  cnt_next;
   logic [15:0] daisy_reg;
   logic [15:0] daisy_next;
   logic        daisy_out_next;
   logic        wr_valid;
   logic        wr_ready;

   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next   = cnt_reg;
      daisy_next = daisy_reg;
      daisy_out_next = o_daisy_out;
      wr_valid   = 1'b0;
      if (sclk_fall) begin
         daisy_next = {daisy_reg[14:0], sdata_s}; // RQ6
         daisy_out_next = daisy_reg[15]; // RQ6
      end
      case (state_reg)
         octdac_pkg::OCTDAC_IDLE: begin
            if (fs_fall) begin
               state_next = octdac_pkg::OCTDAC_SHIFT; // RQ9
               cnt_next   = 5'h00;
            end
         end
         octdac_pkg::OCTDAC_SHIFT: begin
            if (mcu_mode && fs_rise) begin
               state_next = octdac_pkg::OCTDAC_IDLE; // RQ2 RQ1
            end else if (sclk_fall) begin
               shift_next = {shift_reg[14:0], sdata_s}; // RQ15
               cnt_next   = cnt_reg + 5'h01;
               if (cnt_reg + 5'h01 == `OCTDAC_CNT_LAST) begin
                  state_next = mcu_mode ? octdac_pkg::OCTDAC_HOLD : octdac_pkg::OCTDAC_IDLE; // RQ10
                  wr_valid   = ~mcu_mode; // RQ16 RQ4
                  if (!mcu_mode && !wr_ready) begin
                     state_next = octdac_pkg::OCTDAC_HOLD;
                  end
               end
            end
         end
         octdac_pkg::OCTDAC_HOLD: begin
            if (!mcu_mode || fs_rise || s2_reg[2]) begin
               wr_valid = 1'b1; // RQ3
               if (wr_ready) begin
                  state_next = octdac_pkg::OCTDAC_IDLE;
               end
            end
         end
         default: state_next = octdac_pkg::OCTDAC_IDLE;
      endcase
   end

   logic [15:0] wr_word;
   assign wr_word = (state_reg == octdac_pkg::OCTDAC_HOLD) ? shift_reg : shift_next;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= octdac_pkg::OCTDAC_IDLE;
         shift_reg <= 16'h0000;
         cnt_reg   <= 5'h00;
         daisy_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg   <= cnt_next;
         daisy_reg <= daisy_next;
      end
   end

   // Two-entry buffer between the receiver and the register file.
   logic [15:0] buf_mem [0:1];
   logic        wp_reg;
   logic        rp_reg;
   logic [1:0]  fill_reg;
   logic        wp_next;
   logic        rp_next;
   logic [1:0]  fill_next;
   logic        rd_valid;
   logic        rd_ready;
   logic        push;
   logic        pop;
   logic [15:0] rd_word;
   assign wr_ready = (fill_reg != 2'h2);
   assign rd_valid = (fill_reg != 2'h0);
   assign rd_ready = 1'b1;
   assign push     = wr_valid & wr_ready;
   assign pop      = rd_valid & rd_ready;
   assign rd_word  = buf_mem[rp_reg];

   always_comb begin
      wp_next   = push ? ~wp_reg : wp_reg;
      rp_next   = pop ? ~rp_reg : rp_reg;
      fill_next = fill_reg + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wp_reg   <= 1'b0;
         rp_reg   <= 1'b0;
         fill_reg <= 2'h0;
      end else begin
         wp_reg   <= wp_next;
         rp_reg   <= rp_next;
         fill_reg <= fill_next;
      end
      if (push) begin
         buf_mem[wp_reg] <= wr_word;
      end
   end

   // Register file and converter codes.
   logic [11:0] code_reg [0:7];
   logic [11:0] code_next [0:7];
   logic [11:0] dac_reg [0:7];
   logic [11:0] dac_next [0:7];
   logic [11:0] ctrl0_reg;
   logic [11:0] ctrl1_reg;
   logic [11:0] preset_reg;
   logic [11:0] ctrl0_next;
   logic [11:0] ctrl1_next;
   logic [11:0] preset_next;
   logic [3:0]  addr;
   logic [11:0] data;
   assign addr = rd_word[`OCTDAC_ADDR_MSB:`OCTDAC_ADDR_LSB]; // RQ12
   assign data = rd_word[`OCTDAC_CODE_BITS-1:0]; // RQ11

   always_comb begin
      ctrl0_next  = ctrl0_reg;
      ctrl1_next  = ctrl1_reg;
      preset_next = preset_reg;
      for (int i = 0; i < 8; i++) begin
         code_next[i] = code_reg[i];
         dac_next[i]  = load_n_s ? dac_reg[i] : code_reg[i]; // RQ14
      end
      if (pop) begin
         if (!addr[`OCTDAC_CHAN_BIT]) begin
            code_next[addr[2:0]] = data; // RQ13
         end else if (addr[2]) begin
            code_next[{addr[1:0], 1'b0}] = data;
            code_next[{addr[1:0], 1'b1}] = ~data;
         end else if (addr == `OCTDAC_ADDR_CTRL0) begin
            ctrl0_next = data;
         end else if (addr == `OCTDAC_ADDR_CTRL1) begin
            ctrl1_next = data;
         end else if (addr == `OCTDAC_ADDR_PRESET) begin
            preset_next = data;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         for (int i = 0; i < 8; i++) begin
            code_reg[i] <= `OCTDAC_CODE_RESET; // RQ7
            dac_reg[i]  <= `OCTDAC_CODE_RESET;
         end
         ctrl0_reg   <= 12'h000;
         ctrl1_reg   <= 12'h000;
         preset_reg  <= 12'h000;
         o_daisy_out <= 1'b0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            code_reg[i] <= code_next[i];
            dac_reg[i]  <= dac_next[i];
         end
         ctrl0_reg   <= ctrl0_next;
         ctrl1_reg   <= ctrl1_next;
         preset_reg  <= preset_next;
         o_daisy_out <= daisy_out_next; // RQ6
      end
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         o_dac_codes[i*12 +: 12] = dac_reg[i];
      end
      o_ctrl0  = ctrl0_reg;
      o_ctrl1  = ctrl1_reg;
      o_preset = preset_reg;
   end
endmodule

// ===== bench/octdac_monitor.sv
// Port checker for the converter serial front end.
`timescale 1ns/1ps
module octdac_chk (
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic        i_sclk,
   input wire logic        i_frame_sync,
   input wire logic        i_load_strobe_n,
   input wire logic        o_daisy_out,
   input wire logic [95:0] o_dac_codes,
   input wire logic [11:0] o_ctrl0,
   input wire logic [11:0] o_ctrl1,
   input wire logic [11:0] o_preset
);
   logic [2:0] pin_reg, pin_next;
   logic [3:0] fall_reg, fall_next, quiet_reg, quiet_next;
   always_comb begin
      pin_next = {i_sclk, i_frame_sync, i_load_strobe_n};
      fall_next = (pin_reg[2] && !i_sclk) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hF};
      quiet_next = (pin_next != pin_reg) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hF};
   end
   always_ff @(posedge i_clk) begin
      pin_reg <= pin_next;
      fall_reg <= i_reset ? 4'h0 : fall_next;
      quiet_reg <= i_reset ? 4'h0 : quiet_next;
   end
   AST_RST_CODES: assert property (@(posedge i_clk) i_reset |=> o_dac_codes == 96'h0 && !o_daisy_out)
      else $error("codes not cleared");
   AST_RST_REGS: assert property (@(posedge i_clk) i_reset |=> {o_ctrl0, o_ctrl1, o_preset} == 36'h0)
      else $error("registers not cleared");
   AST_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
      i_load_strobe_n && $past(i_load_strobe_n) && $past(i_load_strobe_n, 2) |=> $stable(o_dac_codes))
      else $error("codes moved with strobe high");
   AST_QUIET: assert property (@(posedge i_clk) disable iff (i_reset) quiet_reg > 4'hA |->
      $stable(o_dac_codes) && $stable({o_ctrl0, o_ctrl1, o_preset})) else $error("write without frame");
   AST_DAISY: assert property (@(posedge i_clk) disable iff (i_reset) $changed(o_daisy_out) |-> fall_reg < 4'h7)
      else $error("daisy moved without clock fall");
   AST_ONE_A: assert property (@(posedge i_clk) disable iff (i_reset) $changed(o_ctrl0) |-> $stable(o_ctrl1))
      else $error("two registers written");
   AST_ONE_B: assert property (@(posedge i_clk) disable iff (i_reset) $changed(o_preset) |-> $stable(o_ctrl0))
      else $error("two registers written");
   AST_ONE_C: assert property (@(posedge i_clk) disable iff (i_reset) $changed(o_ctrl1) |-> $stable(o_preset))
      else $error("two registers written");
endmodule
bind octdac_frontend octdac_chk i_chk (.i_clk, .i_reset, .i_sclk, .i_frame_sync, .i_load_strobe_n,
   .o_daisy_out, .o_dac_codes, .o_ctrl0, .o_ctrl1, .o_preset);

// ===== bench/octdac_host_model.sv
// Behavioural host serial port.
`timescale 1ns/1ps
module octdac_host_model (
   output logic o_sclk,
   output logic o_sdata,
   output logic o_frame_sync
);
   initial begin
      {o_sclk, o_sdata, o_frame_sync} = 3'h5;
   end
   // Frame sync rises after cut falls, or stays low when cut is 0.
   task automatic send(input logic [15:0] w, input int cut);
      o_frame_sync = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         o_sdata = w[i];
         o_sclk = 1'b1;
         #200 o_sclk = 1'b0;
         #200 if (16 - i == cut) o_frame_sync = 1'b1;
      end
      o_sclk = 1'b1;
      o_sdata = ~o_sdata;
   endtask
   task automatic rise();
      o_frame_sync = 1'b1;
   endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench for the converter serial front end.
`timescale 1ns/1ps
module tb;
   logic        i_clk, i_reset, i_sclk, i_sdata, i_frame_sync, i_mode_mcu, i_load_strobe_n, o_daisy_out;
   logic [95:0] o_dac_codes;
   logic [11:0] o_ctrl0, o_ctrl1, o_preset;
   logic [11:0] ex [0:10];
   int          failures = 0;
   int          n_compared = 0;
   octdac_frontend i_dut (.i_clk, .i_reset, .i_sclk, .i_sdata, .i_frame_sync, .i_mode_mcu, .i_load_strobe_n,
      .o_daisy_out, .o_dac_codes, .o_ctrl0, .o_ctrl1, .o_preset);
   octdac_host_model i_host (.o_sclk(i_sclk), .o_sdata(i_sdata), .o_frame_sync(i_frame_sync));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic print_verdict();
      if (failures == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_all();
      logic [95:0] c;
      for (int i = 0; i < 8; i++) c[i*12 +: 12] = ex[i];
      chk(o_dac_codes, c);
      chk({o_ctrl0, o_ctrl1, o_preset}, {ex[8], ex[9], ex[10]});
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask
   task automatic send(input logic [15:0] w, input int cut, input logic take);
      logic [3:0] a;
      a = w[15:12];
      i_host.send(w, cut);
      wait_clk(10);
      if (take && a < 4'hB) ex[a] = w[11:0];
      if (take && a > 4'hB) {ex[{a[1:0], 1'b0}], ex[{a[1:0], 1'b1}]} = {w[11:0], ~w[11:0]};
   endtask
   task automatic pins(input logic mcu, input logic strobe_n);
      @(posedge i_clk);
      #5 {i_mode_mcu, i_load_strobe_n} = {mcu, strobe_n};
   endtask
   task automatic t_map();
      for (int a = 0; a < 16; a++) begin
         send({a[3:0], 8'h5A, a[3:0]}, 16, 1'b1);
         chk_all();
      end
      send(16'h7800, 16, 1'b1);
      chk_all();
      send(16'h1FFF, 10, 1'b0);
      chk_all();
   endtask
   task automatic t_late();
      send(16'h2123, 0, 1'b0);
      chk_all();
      i_host.rise();
      wait_clk(10);
      ex[2] = 12'h123;
      chk_all();
   endtask
   task automatic t_strobe();
      pins(1'b1, 1'b1);
      send(16'h0ABC, 16, 1'b0);
      chk(o_dac_codes[11:0], {84'h0, ex[0]});
      pins(1'b1, 1'b0);
      wait_clk(4);
      chk(o_dac_codes[11:0], 96'hABC);
      ex[0] = 12'hABC;
   endtask
   task automatic t_daisy();
      send(16'h0001, 16, 1'b1);
      send(16'h0002, 16, 1'b1);
      chk({95'h0, o_daisy_out}, 96'h1);
      send(16'h0003, 16, 1'b1);
      chk({95'h0, o_daisy_out}, 96'h0);
   endtask
   task automatic t_dsp();
      pins(1'b0, 1'b0);
      send(16'h4321, 1, 1'b1);
      chk_all();
      send(16'h5456, 0, 1'b1);
      chk_all();
      i_host.rise();
   endtask
   initial begin
      {i_reset, i_mode_mcu, i_load_strobe_n} = 3'h6;
      for (int i = 0; i < 11; i++) ex[i] = 12'h000;
      repeat (20) @(posedge i_clk);
      #5 i_reset = 1'b0;
      wait_clk(4);
      chk_all();
      t_map();
      t_late();
      t_strobe();
      t_daisy();
      t_dsp();
      print_verdict();
   end
   initial begin
      #1000000;
      failures++;
      print_verdict();
   end
endmodule
